//--- core/gpcf_pkg.sv
// Constants, register map and reset values for the GPIO ports C to F block
package gpcf_pkg;
	localparam int          GPCF_W         = 8;
	localparam int          GPCF_E_PINS    = 3;
	localparam int          GPCF_F_LOW     = 3;
	// Word-aligned byte addresses on the APB bus
	localparam logic [7:0]  GPCF_C_DIR     = 8'h00;
	localparam logic [7:0]  GPCF_C_PIN     = 8'h04;
	localparam logic [7:0]  GPCF_C_LAT     = 8'h08;
	localparam logic [7:0]  GPCF_D_DIR     = 8'h0C;
	localparam logic [7:0]  GPCF_D_PIN     = 8'h10;
	localparam logic [7:0]  GPCF_D_LAT     = 8'h14;
	localparam logic [7:0]  GPCF_E_DIR     = 8'h18;
	localparam logic [7:0]  GPCF_E_PIN     = 8'h1C;
	localparam logic [7:0]  GPCF_E_LAT     = 8'h20;
	localparam logic [7:0]  GPCF_F_DIR     = 8'h24;
	localparam logic [7:0]  GPCF_F_PIN     = 8'h28;
	localparam logic [7:0]  GPCF_F_LAT     = 8'h2C;
	localparam logic [7:0]  GPCF_CFG       = 8'h30;
	localparam logic [7:0]  GPCF_RST_CAUSE = 8'h34;
	// Reset values and pin masks
	localparam logic [7:0]  GPCF_DIR_RST   = 8'hFF;
	localparam logic [7:0]  GPCF_E_DIR_RST = 8'h07;
	localparam logic [7:0]  GPCF_ZERO      = 8'h00;
	localparam logic [7:0]  GPCF_E_MASK    = 8'h07;
	localparam logic [7:0]  GPCF_F_LOW_M   = 8'h07;
	localparam logic [31:0] GPCF_ZERO32    = 32'h0000_0000;
	// Port E direction register fields
	localparam int          GPCF_IBF_BIT   = 7;
	localparam int          GPCF_OBF_BIT   = 6;
	localparam int          GPCF_SLAVE_INPUT_OVERFLOW_BIT  = 5;
	localparam int          GPCF_MODE_BIT  = 4;
	// Config register fields
	localparam int          GPCF_ALT_BIT   = 0;
	localparam int          GPCF_FLAG_BIT  = 1;
	// Pin numbers for shared functions
	localparam int          GPCF_TMR_PIN   = 0;
	localparam int          GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN  = 1;
	localparam int          GPCF_CCP1_PIN  = 2;
endpackage : gpcf_pkg

//--- core/gpcf_top.sv
// GPIO ports C to F: APB register file, direction override and pin muxing
`timescale 1ns/1ps
module gpcf_top
	import gpcf_pkg::*;
#(
	parameter int W = GPCF_W
) (
	// Clock and reset
	input  wire logic         I_MCLK,
	input  wire logic         I_RST,
	input  wire logic         I_POR,
	// APB slave
	input  wire logic         I_PSEL,
	input  wire logic         I_PENABLE,
	input  wire logic         I_PWRITE,
	input  wire logic [7:0]   I_PADDR,
	input  wire logic [31:0]  I_PWDATA,
	output logic      [31:0]  O_PRDATA,
	output logic              O_PREADY,
	output logic              O_PSLVERR,
	// Port pins
	input  wire logic [W-1:0] I_PC_IN,
	output logic      [W-1:0] O_PC_OUT,
	output logic      [W-1:0] O_PC_OE,
	input  wire logic [W-1:0] I_PD_IN,
	output logic      [W-1:0] O_PD_OUT,
	output logic      [W-1:0] O_PD_OE,
	input  wire logic [W-1:0] I_PE_IN,
	output logic      [W-1:0] O_PE_OUT,
	output logic      [W-1:0] O_PE_OE,
	input  wire logic [W-1:0] I_PF_IN,
	output logic      [W-1:0] O_PF_OUT,
	output logic      [W-1:0] O_PF_OE,
	// Peripheral overrides on port C
	input  wire logic [W-1:0] I_PC_PERI_OUT_EN,
	input  wire logic [W-1:0] I_PC_PERI_IN_EN,
	input  wire logic [W-1:0] I_PC_PERI_DATA,
	input  wire logic         I_TMR_OSC_OUT_EN,
	input  wire logic         I_TMR_OSC_OUT,
	input  wire logic         I_CCP1_OUT_EN,
	input  wire logic         I_CCP1_OUT,
	input  wire logic         I_SECOND_CAPTURE_COMPARE_UNIT_OUT_EN,
	input  wire logic         I_SECOND_CAPTURE_COMPARE_UNIT_OUT,
	output logic              O_TMR_CLK_IN,
	output logic              O_CCP1_IN,
	output logic              O_SECOND_CAPTURE_COMPARE_UNIT_IN,
	// Slave port flags, analog select
	input  wire logic         I_SLAVE_IN_FULL_SET,
	input  wire logic         I_SLAVE_OUT_FULL_SET,
	input  wire logic         I_SLAVE_OVF_SET,
	input  wire logic [W-1:0] I_PF_ANALOG_SEL,
	output logic              O_SLAVE_PORT_EN,
	output logic      [W-1:0] O_PF_ANALOG
);
	// ==========================================
	// Register state
	logic [W-1:0] c_dir, d_dir, f_dir, c_lat, d_lat, f_lat;
	logic [W-1:0] e_dir, e_lat;
	logic [W-1:0] c_s1, c_s2, d_s1, d_s2, e_s1, e_s2, f_s1, f_s2;
	logic         alt_capture_pin_select;
	logic         analog_low_clr;
	logic         por_seen;
	logic         wr, rd;
	logic [W-1:0] wd;
	logic [W-1:0] f_analog;
	logic [GPCF_F_LOW-1:0] f_lat_lo;
	logic [W-1:GPCF_F_LOW] f_lat_hi;
	logic [W-1:0] pc_force_out, pc_force_in, pc_pdata;

	assign wr = I_PSEL && I_PENABLE && I_PWRITE;
	assign rd = I_PSEL && I_PENABLE && !I_PWRITE;
	assign wd = I_PWDATA[W-1:0];

	// ==========================================
	// Pin synchronisers
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			c_s1 <= GPCF_ZERO;
			c_s2 <= GPCF_ZERO;
			d_s1 <= GPCF_ZERO;
			d_s2 <= GPCF_ZERO;
			e_s1 <= GPCF_ZERO;
			e_s2 <= GPCF_ZERO;
			f_s1 <= GPCF_ZERO;
			f_s2 <= GPCF_ZERO;
		end else begin
			c_s1 <= I_PC_IN;
			c_s2 <= c_s1;
			d_s1 <= I_PD_IN;
			d_s2 <= d_s1;
			e_s1 <= I_PE_IN;
			e_s2 <= e_s1;
			f_s1 <= I_PF_IN;
			f_s2 <= f_s1;
		end
	end

	// ==========================================
	// Direction registers
	// Stored bits move only by software, overrides never touch them
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			c_dir <= GPCF_DIR_RST;
			d_dir <= GPCF_DIR_RST;
			f_dir <= GPCF_DIR_RST;
		end else if (wr) begin
			if (I_PADDR == GPCF_C_DIR) c_dir <= wd;
			if (I_PADDR == GPCF_D_DIR) d_dir <= wd;
			if (I_PADDR == GPCF_F_DIR) f_dir <= wd;
		end
	end

	// Port E: low bits direction, upper bits slave port flags
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			e_dir <= GPCF_E_DIR_RST;
		end else begin
			if (wr && I_PADDR == GPCF_E_DIR) begin
				e_dir[GPCF_E_PINS-1:0]  <= wd[GPCF_E_PINS-1:0];
				e_dir[GPCF_MODE_BIT]    <= wd[GPCF_MODE_BIT];
				e_dir[GPCF_SLAVE_INPUT_OVERFLOW_BIT]    <= wd[GPCF_SLAVE_INPUT_OVERFLOW_BIT];
			end
			// Overflow flag set by the slave port wins over a software clear; IBF and OBF have no software clear
			if (I_SLAVE_IN_FULL_SET) e_dir[GPCF_IBF_BIT] <= 1'b1;
			if (I_SLAVE_OUT_FULL_SET) e_dir[GPCF_OBF_BIT] <= 1'b1;
			if (I_SLAVE_OVF_SET) e_dir[GPCF_SLAVE_INPUT_OVERFLOW_BIT] <= 1'b1;
		end
	end

	// ==========================================
	// Output latches
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			c_lat <= GPCF_ZERO;
			d_lat <= GPCF_ZERO;
			e_lat <= GPCF_ZERO;
		end else if (wr) begin
			if (I_PADDR == GPCF_C_LAT || I_PADDR == GPCF_C_PIN) c_lat <= wd;
			if (I_PADDR == GPCF_D_LAT || I_PADDR == GPCF_D_PIN) d_lat <= wd;
			if (I_PADDR == GPCF_E_LAT || I_PADDR == GPCF_E_PIN)
				e_lat <= wd & GPCF_E_MASK;
		end
	end

	// Port F latch keeps upper bits over a warm reset
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			f_lat_lo <= '0;
		end else if (wr && (I_PADDR == GPCF_F_LAT || I_PADDR == GPCF_F_PIN)) begin
			f_lat_lo <= wd[GPCF_F_LOW-1:0];
		end
	end

	assign f_lat = {f_lat_hi, f_lat_lo};

	// Upper bits are not reset asynchronously; a power-on strobe clears them
	always_ff @(posedge I_MCLK) begin
		if (I_POR) begin
			f_lat_hi <= '0;
		end else if (wr && (I_PADDR == GPCF_F_LAT || I_PADDR == GPCF_F_PIN)) begin
			f_lat_hi <= wd[W-1:GPCF_F_LOW];
		end
	end

	// ==========================================
	// Configuration: alternate capture pin, analog low pins
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			alt_capture_pin_select <= 1'b0;
			analog_low_clr         <= 1'b0;
			por_seen               <= 1'b0;
		end else begin
			if (wr && I_PADDR == GPCF_CFG) begin
				alt_capture_pin_select <= wd[GPCF_ALT_BIT];
				analog_low_clr         <= wd[GPCF_FLAG_BIT];
			end
			if (I_POR) por_seen <= 1'b1;
			else if (wr && I_PADDR == GPCF_RST_CAUSE) por_seen <= 1'b0;
		end
	end

	// Low port F pins analog until software releases them
	always_comb begin
		f_analog = I_PF_ANALOG_SEL;
		if (!analog_low_clr) f_analog[GPCF_F_LOW-1:0] = '1;
	end

	// ==========================================
	// Port C peripheral override
	always_comb begin
		pc_force_out = I_PC_PERI_OUT_EN;
		pc_force_in  = I_PC_PERI_IN_EN;
		pc_pdata     = I_PC_PERI_DATA;
		pc_force_out[GPCF_TMR_PIN] = I_TMR_OSC_OUT_EN;
		pc_pdata[GPCF_TMR_PIN]     = I_TMR_OSC_OUT;
		pc_force_out[GPCF_CCP1_PIN] = I_CCP1_OUT_EN;
		pc_pdata[GPCF_CCP1_PIN]     = I_CCP1_OUT;
		pc_force_out[GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN] = alt_capture_pin_select && I_SECOND_CAPTURE_COMPARE_UNIT_OUT_EN;
		pc_pdata[GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN]     = I_SECOND_CAPTURE_COMPARE_UNIT_OUT;
	end

	// ==========================================
	// Pin drivers, registered
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_PC_OE  <= GPCF_ZERO;
			O_PC_OUT <= GPCF_ZERO;
			O_PD_OE  <= GPCF_ZERO;
			O_PD_OUT <= GPCF_ZERO;
			O_PE_OE  <= GPCF_ZERO;
			O_PE_OUT <= GPCF_ZERO;
			O_PF_OE  <= GPCF_ZERO;
			O_PF_OUT <= GPCF_ZERO;
		end else begin
			// Override beats direction bit
			O_PC_OE  <= pc_force_out | (~pc_force_in & ~c_dir);
			O_PC_OUT <= (pc_force_out & pc_pdata) | (~pc_force_out & c_lat);
			O_PD_OE  <= ~d_dir;
			O_PD_OUT <= d_lat;
			O_PE_OE  <= ~e_dir & GPCF_E_MASK;
			O_PE_OUT <= e_lat;
			O_PF_OE  <= ~f_dir;
			O_PF_OUT <= f_lat;
		end
	end

	// Peripheral inputs and status outputs
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_TMR_CLK_IN    <= 1'b0;
			O_CCP1_IN       <= 1'b0;
			O_SECOND_CAPTURE_COMPARE_UNIT_IN       <= 1'b0;
			O_SLAVE_PORT_EN <= 1'b0;
			O_PF_ANALOG     <= GPCF_ZERO;
		end else begin
			O_TMR_CLK_IN    <= c_s2[GPCF_TMR_PIN];
			O_CCP1_IN       <= c_s2[GPCF_CCP1_PIN];
			O_SECOND_CAPTURE_COMPARE_UNIT_IN       <= alt_capture_pin_select & c_s2[GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN];
			O_SLAVE_PORT_EN <= e_dir[GPCF_MODE_BIT];
			O_PF_ANALOG     <= f_analog;
		end
	end

	// ==========================================
	// APB read path, zero wait states
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_PRDATA  <= GPCF_ZERO32;
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= I_PSEL && !I_PENABLE;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= GPCF_ZERO32;
			if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
				unique case (I_PADDR)
					GPCF_C_DIR: O_PRDATA[W-1:0] <= c_dir;
					GPCF_C_PIN: O_PRDATA[W-1:0] <= c_s2;
					GPCF_C_LAT: O_PRDATA[W-1:0] <= c_lat;
					GPCF_D_DIR: O_PRDATA[W-1:0] <= d_dir;
					GPCF_D_PIN: O_PRDATA[W-1:0] <= d_s2;
					GPCF_D_LAT: O_PRDATA[W-1:0] <= d_lat;
					GPCF_E_DIR: O_PRDATA[W-1:0] <= e_dir;
					GPCF_E_PIN: O_PRDATA[W-1:0] <= e_s2 & GPCF_E_MASK;
					GPCF_E_LAT: O_PRDATA[W-1:0] <= e_lat;
					GPCF_F_DIR: O_PRDATA[W-1:0] <= f_dir;
					GPCF_F_PIN: O_PRDATA[W-1:0] <= f_s2 & ~f_analog;
					GPCF_F_LAT: O_PRDATA[W-1:0] <= f_lat;
					GPCF_CFG: O_PRDATA[1:0] <= {analog_low_clr, alt_capture_pin_select};
					GPCF_RST_CAUSE: O_PRDATA[0] <= por_seen;
					default: O_PSLVERR <= 1'b1;
				endcase
			end else if (I_PSEL && !I_PENABLE && I_PWRITE) begin
				unique case (I_PADDR)
					GPCF_C_DIR, GPCF_C_PIN, GPCF_C_LAT, GPCF_D_DIR, GPCF_D_PIN,
					GPCF_D_LAT, GPCF_E_DIR, GPCF_E_PIN, GPCF_E_LAT, GPCF_F_DIR,
					GPCF_F_PIN, GPCF_F_LAT, GPCF_CFG, GPCF_RST_CAUSE: O_PSLVERR <= 1'b0;
					default: O_PSLVERR <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================
	// Checks
	dir_reset_a: assert property (@(posedge I_MCLK) $fell(I_RST) |-> c_dir == GPCF_DIR_RST)
		else $error("port C direction not all ones after reset");
	dir_stored_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		wr && I_PADDR == GPCF_C_DIR |=> c_dir == $past(wd))
		else $error("direction write not stored");
	force_out_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_PC_PERI_OUT_EN[4] |=> O_PC_OE[4])
		else $error("peripheral output not forced");
	force_in_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_PC_PERI_IN_EN[3] && !I_PC_PERI_OUT_EN[3] |=> !O_PC_OE[3])
		else $error("peripheral input not forced");
	second_capture_compare_unit_gate_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		!alt_capture_pin_select |=> !O_PC_OE[GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN] || !c_dir[GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN]
		|| !$past(c_dir[GPCF_SECOND_CAPTURE_COMPARE_UNIT_PIN]))
		else $error("capture two drove pin while not selected");
	d_drive_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		##1 O_PD_OE == ~$past(d_dir) && O_PD_OUT == $past(d_lat))
		else $error("port D driver mismatch");
	f_low_zero_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		rd && I_PADDR == GPCF_F_PIN && !analog_low_clr |-> O_PRDATA[2:0] == 3'h0)
		else $error("analog low pins not zero");
	e_unimpl_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		rd && I_PADDR == GPCF_E_LAT |-> O_PRDATA[7:3] == 5'h00)
		else $error("port E unimplemented bits set");
	ready_a: assert property (@(posedge I_MCLK) disable iff (I_RST)
		I_PSEL && !I_PENABLE |=> O_PREADY)
		else $error("no ready in access phase");
	c_out_cov: cover property (@(posedge I_MCLK) O_PC_OE[0] && !c_dir[0]);
	c_ovr_cov: cover property (@(posedge I_MCLK) I_PC_PERI_OUT_EN[4] && c_dir[4]);
	f_rd_cov: cover property (@(posedge I_MCLK) rd && I_PADDR == GPCF_F_PIN);
endmodule : gpcf_top

//--- testbench/gpcf_pins.sv
// Pin model: each pin carries the block's drive when enabled, else the outside level
`timescale 1ns/1ps
module gpcf_pins (
	// Block side
	input  wire logic [7:0] i_oe,
	input  wire logic [7:0] i_out,
	// Outside driver
	input  wire logic [7:0] i_ext,
	output logic      [7:0] o_pin
);
	// Resolved wire level per pin
	assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule : gpcf_pins

//--- testbench/test_gpio_ports_c_to_f.sv
// Self-checking bench for the GPIO ports C to F block
`timescale 1ns/1ps
module test_gpio_ports_c_to_f import gpcf_pkg::*;;
	logic        mclk, rst, por, psel, pen, pwr, pready, pslverr, err;
	logic [7:0]  paddr, v, pc_ext, pd_ext, pe_ext, pf_ext, po_en, pi_en, p_dat, an_sel, an_out;
	logic [31:0] pwdata, prdata, rdat;
	logic [7:0]  pc_in, pc_out, pc_oe, pd_in, pd_out, pd_oe;
	logic [7:0]  pe_in, pe_out, pe_oe, pf_in, pf_out, pf_oe;
	logic        t_en, t_o, c1_en, c1_o, c2_en, c2_o, t_i, c1_i, c2_i, s_in, s_out, s_ovf, sp_en;
	logic [31:0] seed = 32'hFF846CB3;
	logic [7:0]  lat_a [4];
	logic [7:0]  lat_m [4];
	int          mismatches = 0;
	int          tests_run = 0;
	int          cyc = 0;
	gpcf_top i_gpcf_top (.I_MCLK(mclk), .I_RST(rst), .I_POR(por), .I_PSEL(psel),
		.I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_PC_IN(pc_in), .O_PC_OUT(pc_out), .O_PC_OE(pc_oe),
		.I_PD_IN(pd_in), .O_PD_OUT(pd_out), .O_PD_OE(pd_oe),
		.I_PE_IN(pe_in), .O_PE_OUT(pe_out), .O_PE_OE(pe_oe),
		.I_PF_IN(pf_in), .O_PF_OUT(pf_out), .O_PF_OE(pf_oe),
		.I_PC_PERI_OUT_EN(po_en), .I_PC_PERI_IN_EN(pi_en), .I_PC_PERI_DATA(p_dat),
		.I_TMR_OSC_OUT_EN(t_en), .I_TMR_OSC_OUT(t_o), .I_CCP1_OUT_EN(c1_en),
		.I_CCP1_OUT(c1_o), .I_SECOND_CAPTURE_COMPARE_UNIT_OUT_EN(c2_en), .I_SECOND_CAPTURE_COMPARE_UNIT_OUT(c2_o),
		.O_TMR_CLK_IN(t_i), .O_CCP1_IN(c1_i), .O_SECOND_CAPTURE_COMPARE_UNIT_IN(c2_i),
		.I_SLAVE_IN_FULL_SET(s_in), .I_SLAVE_OUT_FULL_SET(s_out), .I_SLAVE_OVF_SET(s_ovf),
		.I_PF_ANALOG_SEL(an_sel), .O_SLAVE_PORT_EN(sp_en), .O_PF_ANALOG(an_out));
	gpcf_pins i_gpcf_pins_c (.i_oe(pc_oe), .i_out(pc_out), .i_ext(pc_ext), .o_pin(pc_in));
	gpcf_pins i_gpcf_pins_d (.i_oe(pd_oe), .i_out(pd_out), .i_ext(pd_ext), .o_pin(pd_in));
	gpcf_pins i_gpcf_pins_e (.i_oe(pe_oe), .i_out(pe_out), .i_ext(pe_ext), .o_pin(pe_in));
	gpcf_pins i_gpcf_pins_f (.i_oe(pf_oe), .i_out(pf_out), .i_ext(pf_ext), .o_pin(pf_in));
	// ==========================================
	// Clock, timeout and helpers
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Request held until pready is seen in the access cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, pready, 1'b1);
		end
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {rnd() & 32'hFFFFFF00} | {24'h0, d});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, {24'h0, exp});
	endtask : rd
	task automatic settle();
		repeat (4) @(negedge mclk);
	endtask : settle
	task automatic do_reset(input logic p);
		@(posedge mclk);
		rst <= 1'b1;
		por <= p;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		por <= 1'b0;
	endtask : do_reset
	// ==========================================
	// Main sequence
	initial begin
		{psel, pen, pwr, t_en, t_o, c1_en, c1_o, c2_en, c2_o, s_in, s_out, s_ovf} = '0;
		{paddr, pwdata, pc_ext, pd_ext, pe_ext, pf_ext, po_en, pi_en, p_dat} = '0;
		an_sel = 8'h07;
		rst = 1'b1;
		por = 1'b1;
		lat_a = '{GPCF_C_LAT, GPCF_D_LAT, GPCF_E_LAT, GPCF_F_LAT};
		lat_m = '{8'hFF, 8'hFF, GPCF_E_MASK, 8'hFF};
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		por <= 1'b0;
		rd(GPCF_C_DIR, 8'hFF);
		rd(GPCF_D_DIR, 8'hFF);
		rd(GPCF_F_DIR, 8'hFF);
		rd(GPCF_E_DIR, 8'h07);
		rd(GPCF_F_LAT, 8'h00);
		rd(GPCF_RST_CAUSE, 8'h00);
		chk({24'h0, pc_oe | pd_oe | pe_oe | pf_oe}, 32'h0);
		chk({24'h0, an_out}, 32'h07);
		apb(1'b0, 8'h3C, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rdat, 32'h0);
		for (int i = 0; i < 4; i++) begin
			v = 8'(rnd());
			wr(lat_a[i], v);
			rd(lat_a[i], v & lat_m[i]);
		end
		wr(GPCF_D_LAT, 8'h96);
		wr(GPCF_D_DIR, 8'h00);
		settle();
		chk({16'h0, pd_oe, pd_out}, 32'h0000_FF96);
		rd(GPCF_D_PIN, 8'h96);
		wr(GPCF_C_PIN, 8'h5A);
		rd(GPCF_C_LAT, 8'h5A);
		@(posedge mclk) pc_ext <= 8'(rnd());
		settle();
		rd(GPCF_C_PIN, pc_ext);
		// Peripheral overrides on port C
		wr(GPCF_C_DIR, 8'h00);
		settle();
		chk({16'h0, pc_oe, pc_out}, 32'h0000_FF5A);
		@(posedge mclk) pi_en <= 8'h78;
		settle();
		chk({24'h0, pc_oe}, 32'h87);
		wr(GPCF_C_DIR, 8'hF0);
		wr(GPCF_C_DIR, 8'h00);
		settle();
		chk({24'h0, pc_oe}, 32'h87);
		rd(GPCF_C_DIR, 8'h00);
		@(posedge mclk);
		pi_en <= 8'h00;
		po_en <= 8'hF0;
		p_dat <= 8'h50;
		wr(GPCF_C_DIR, 8'hFF);
		settle();
		chk({16'h0, pc_oe, pc_out & 8'hF0}, 32'h0000_F050);
		@(posedge mclk) po_en <= 8'h00;
		settle();
		chk({24'h0, pc_oe}, 32'h0);
		// Shared functions on pins C0 to C2
		@(posedge mclk) pc_ext <= 8'h07;
		settle();
		chk({29'h0, t_i, c1_i, c2_i}, 32'h6);
		wr(GPCF_CFG, 8'h01);
		@(posedge mclk);
		{t_en, t_o, c1_en, c1_o, c2_en, c2_o} <= 6'b10_11_11;
		settle();
		chk({29'h0, c2_i, pc_oe[2:1]}, 32'h7);
		chk({24'h0, pc_oe & 8'h07, pc_out & 8'h07}, 32'h0706);
		wr(GPCF_CFG, 8'h00);
		settle();
		chk({31'h0, pc_oe[1]}, 32'h0);
		// Port F analog pins
		@(posedge mclk) pf_ext <= 8'hFF;
		settle();
		rd(GPCF_F_PIN, 8'hF8);
		wr(GPCF_F_DIR, 8'h00);
		settle();
		chk({24'h0, pf_oe}, 32'hFF);
		wr(GPCF_F_DIR, 8'hFF);
		wr(GPCF_CFG, 8'h02);
		@(posedge mclk) an_sel <= 8'h00;
		settle();
		chk({24'h0, an_out}, 32'h00);
		rd(GPCF_F_PIN, 8'hFF);
		// Port E direction and slave flags
		wr(GPCF_E_DIR, 8'hFF);
		rd(GPCF_E_DIR, 8'h37);
		chk({31'h0, sp_en}, 32'h1);
		@(posedge mclk) {s_in, s_out, s_ovf} <= 3'b111;
		@(posedge mclk) {s_in, s_out, s_ovf} <= 3'b000;
		wr(GPCF_E_DIR, 8'h00);
		rd(GPCF_E_DIR, 8'hC0);
		// Warm and power-on resets of port F
		wr(GPCF_F_LAT, 8'hFF);
		@(posedge mclk) an_sel <= 8'h07;
		do_reset(1'b0);
		rd(GPCF_F_LAT, 8'hF8);
		rd(GPCF_F_DIR, 8'hFF);
		rd(GPCF_F_PIN, 8'hF8);
		do_reset(1'b1);
		rd(GPCF_F_LAT, 8'h00);
		tally_and_finish();
	end
endmodule : test_gpio_ports_c_to_f
